// >>> hdl/uart_flow_trigger_config.sv
// enhanced feature, divisor, threshold and trigger configuration of one uart channel
`timescale 1ns/10ps
// How it works
// - feature bit 7 set: transmitter holds while clear-to-send pin reads high
// - feature bit 6 set: request-to-send high at halt level, low at resume
// - feature bit 5 set: received char equal to second pause char pulses special_char_q
// - feature bit 4 gates writes to protected interrupt, fifo and modem bits
// - feature bits 3:0 select the software flow control combination
// - divisor is high latch as upper byte, low latch as lower byte
// - divisor latches writable only while sleep bit is clear
// - threshold holds resume level high nibble, halt level low nibble, steps of four
// - threshold writable only with feature bit 4 and modem bit 6 set
// - trigger register: receive level high nibble, transmit level low nibble, times four
// - trigger register writable only with feature bit 4 and modem bit 6 set
// - zero trigger nibble falls back to the fifo_control selected level
// - ready bits 7:4 show live receive readiness per channel
// - ready bits 3:0 show live transmit readiness per channel
// - ready register read-only at address 7 with enable bit and no loop-back
`include "uart_flow_cfg.svh"

module uart_flow_trigger_config (
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       bus_sel_n,
	input  wire logic [2:0] bus_addr,
	input  wire logic       bus_wr,
	input  wire logic       bus_rd,
	input  wire logic [7:0] bus_wdata,
	output logic      [7:0] bus_rdata_q,
	input  wire logic       cts_pin_n,
	output logic            rts_pin_n_q,
	output logic            tx_hold_q,
	input  wire logic       rx_char_valid,
	input  wire logic [7:0] rx_char,
	output logic            special_char_q,
	input  wire logic [6:0] rx_fill,
	input  wire logic [6:0] tx_fill,
	input  wire logic       rx_timeout,
	input  wire logic [3:0] peer_rx_ready,
	input  wire logic [3:0] peer_tx_ready,
	output logic      [15:0] divisor_q,
	output logic      [3:0] sw_flow_mode_q,
	output logic      [5:0] rx_trig_q,
	output logic      [5:0] tx_trig_q,
	output logic      [7:0] interrupt_enable_q,
	output logic      [7:0] fifo_control_q,
	output logic      [7:0] modem_control_q,
	output logic      [7:0] line_control_q
);

	// ------------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------------
	logic [7:0] enhanced_feature_ctrl_q;
	logic [7:0] flow_threshold_q;
	logic [7:0] fifo_trigger_level_q;
	logic [7:0] second_pause_char_q;
	logic [7:0] fifo_ready_status;
	logic [7:0] rd_mux;
	logic       wr;
	logic       key_mode;
	logic       div_mode;
	logic       ext_wr_ok;
	logic       rdy_visible;
	logic       cts_meta_q;
	logic       cts_sync_q;
	logic [6:0] halt_lvl;
	logic [6:0] resume_lvl;
	logic [6:0] tx_free;
	logic       own_rx_ready;
	logic       own_tx_ready;
	uart_flow_pkg::rts_state_e rts_state_q;

	// bus strobes come from logic on ref_clk, so no synchroniser here
	assign wr          = bus_wr & ~bus_sel_n;
	assign key_mode    = (line_control_q == `FEAT_KEY);
	assign div_mode    = line_control_q[`LCTL_DIV_BIT];
	// both threshold and trigger share the same gate
	assign ext_wr_ok   = enhanced_feature_ctrl_q[`FEAT_WEN_BIT]
	                   & modem_control_q[`MCTL_TRIG_BIT];
	assign rdy_visible = modem_control_q[`MCTL_RDY_BIT]
	                   & ~modem_control_q[`MCTL_LOOP_BIT];

	// ------------------------------------------------------------------------
	// base registers with protected fields
	// ------------------------------------------------------------------------
	// line control is always reachable so software can leave the key mode
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			line_control_q <= `REG_RESET;
		end else if (wr && bus_addr == `ADDR_LCTL) begin
			line_control_q <= bus_wdata;
		end
	end

	// protected bits keep their value unless the write enable is open
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			interrupt_enable_q <= `REG_RESET;
			fifo_control_q     <= `REG_RESET;
			modem_control_q    <= `REG_RESET;
		end else if (wr && !div_mode) begin
			if (bus_addr == `ADDR_IEN) begin
				interrupt_enable_q <= enhanced_feature_ctrl_q[`FEAT_WEN_BIT] ? bus_wdata
				    : (interrupt_enable_q & `IEN_PROT_MASK)
				    | (bus_wdata & ~`IEN_PROT_MASK);
			end
			if (bus_addr == `ADDR_FCTL) begin
				fifo_control_q <= enhanced_feature_ctrl_q[`FEAT_WEN_BIT] ? bus_wdata
				    : (fifo_control_q & `FCTL_PROT_MASK)
				    | (bus_wdata & ~`FCTL_PROT_MASK);
			end
			if (bus_addr == `ADDR_MCTL) begin
				modem_control_q <= enhanced_feature_ctrl_q[`FEAT_WEN_BIT] ? bus_wdata
				    : (modem_control_q & `MCTL_PROT_MASK)
				    | (bus_wdata & ~`MCTL_PROT_MASK);
			end
		end
	end

	// ------------------------------------------------------------------------
	// key-mode registers
	// ------------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			enhanced_feature_ctrl_q <= `REG_RESET;
			second_pause_char_q     <= `REG_RESET;
		end else if (wr && key_mode) begin
			if (bus_addr == `ADDR_FEAT) begin
				enhanced_feature_ctrl_q <= bus_wdata;
			end
			if (bus_addr == `ADDR_PAUSE2) begin
				second_pause_char_q <= bus_wdata;
			end
		end
	end

	// the low nibble is handed to the software flow logic as is
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sw_flow_mode_q <= 4'h0;
		end else begin
			sw_flow_mode_q <= enhanced_feature_ctrl_q[3:0];
		end
	end

	// divisor latches freeze once sleep is enabled
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			divisor_q <= 16'h0000;
		end else if (wr && div_mode && !interrupt_enable_q[`IEN_SLEEP_BIT]) begin
			if (bus_addr == `ADDR_DIV_LO) begin
				divisor_q[7:0] <= bus_wdata;
			end
			if (bus_addr == `ADDR_DIV_HI) begin
				divisor_q[15:8] <= bus_wdata;
			end
		end
	end

	// threshold and trigger share the enable; halt above resume is not checked
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			flow_threshold_q     <= `REG_RESET;
			fifo_trigger_level_q <= `REG_RESET;
		end else if (wr && !div_mode && ext_wr_ok) begin
			if (bus_addr == `ADDR_THRESH) begin
				flow_threshold_q <= bus_wdata;
			end
			if (bus_addr == `ADDR_TRIG) begin
				fifo_trigger_level_q <= bus_wdata;
			end
		end
	end

	// ------------------------------------------------------------------------
	// effective trigger levels
	// ------------------------------------------------------------------------
	// nibble times four, zero nibble falls back to the fifo_control pick
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rx_trig_q <= `RX_SEL_LVL0;
			tx_trig_q <= `TX_SEL_LVL0;
		end else begin
			if (fifo_trigger_level_q[7:4] != 4'h0) begin
				rx_trig_q <= {fifo_trigger_level_q[7:4], 2'b00};
			end else begin
				case (fifo_control_q[7:6])
					2'd0:    rx_trig_q <= `RX_SEL_LVL0;
					2'd1:    rx_trig_q <= `RX_SEL_LVL1;
					2'd2:    rx_trig_q <= `RX_SEL_LVL2;
					default: rx_trig_q <= `RX_SEL_LVL3;
				endcase
			end
			if (fifo_trigger_level_q[3:0] != 4'h0) begin
				tx_trig_q <= {fifo_trigger_level_q[3:0], 2'b00};
			end else begin
				case (fifo_control_q[5:4])
					2'd0:    tx_trig_q <= `TX_SEL_LVL0;
					2'd1:    tx_trig_q <= `TX_SEL_LVL1;
					2'd2:    tx_trig_q <= `TX_SEL_LVL2;
					default: tx_trig_q <= `TX_SEL_LVL3;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------------
	// hardware flow control
	// ------------------------------------------------------------------------
	// clear-to-send is an asynchronous pin: two flops before use
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cts_meta_q <= 1'b1;
			cts_sync_q <= 1'b1;
		end else begin
			cts_meta_q <= cts_pin_n;
			cts_sync_q <= cts_meta_q;
		end
	end

	// high pin means the far end is not ready
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tx_hold_q <= 1'b0;
		end else begin
			tx_hold_q <= enhanced_feature_ctrl_q[`FEAT_CTS_BIT] & cts_sync_q;
		end
	end

	assign halt_lvl   = {1'b0, flow_threshold_q[3:0], 2'b00};
	assign resume_lvl = {1'b0, flow_threshold_q[7:4], 2'b00};

	// hysteresis: halt once fill reaches halt, resume once it drains to resume
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rts_state_q <= uart_flow_pkg::RTS_RESUMED;
		end else if (!enhanced_feature_ctrl_q[`FEAT_RTS_BIT]) begin
			rts_state_q <= uart_flow_pkg::RTS_RESUMED;
		end else begin
			case (rts_state_q)
				uart_flow_pkg::RTS_RESUMED: begin
					if (rx_fill >= halt_lvl) begin
						rts_state_q <= uart_flow_pkg::RTS_HALTED;
					end
				end
				uart_flow_pkg::RTS_HALTED: begin
					if (rx_fill <= resume_lvl && rx_fill < halt_lvl) begin
						rts_state_q <= uart_flow_pkg::RTS_RESUMED;
					end
				end
				default: rts_state_q <= uart_flow_pkg::RTS_RESUMED;
			endcase
		end
	end

	// pin follows the state one cycle later; low means send
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rts_pin_n_q <= 1'b0;
		end else begin
			rts_pin_n_q <= (rts_state_q == uart_flow_pkg::RTS_HALTED);
		end
	end

	// char still goes to the fifo; this only raises the flag pulse
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			special_char_q <= 1'b0;
		end else begin
			special_char_q <= rx_char_valid
			    & enhanced_feature_ctrl_q[`FEAT_SPEC_BIT]
			    & (rx_char == second_pause_char_q);
		end
	end

	// ------------------------------------------------------------------------
	// fifo ready summary
	// ------------------------------------------------------------------------
	assign tx_free      = `FIFO_DEPTH - tx_fill;
	assign own_rx_ready = (rx_fill > {1'b0, rx_trig_q}) | rx_timeout;
	assign own_tx_ready = (tx_free >= {1'b0, tx_trig_q});

	// own channel computed here, the others come from their blocks
	for (genvar ch = 0; ch < 4; ch++) begin : g_rdy
		if (ch == `CHAN_IDX) begin : g_own
			assign fifo_ready_status[4 + ch] = own_rx_ready;
			assign fifo_ready_status[ch]     = own_tx_ready;
		end else begin : g_peer
			assign fifo_ready_status[4 + ch] = peer_rx_ready[ch];
			assign fifo_ready_status[ch]     = peer_tx_ready[ch];
		end
	end

	// ------------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------------
	// address 7 reads the pause char in key mode, else the ready summary wins over the trigger
	always_comb begin
		rd_mux = 8'h00;
		case (bus_addr)
			3'h0: rd_mux = div_mode ? divisor_q[7:0] : 8'h00;
			3'h1: rd_mux = div_mode ? divisor_q[15:8] : interrupt_enable_q;
			3'h2: rd_mux = key_mode ? enhanced_feature_ctrl_q : 8'h00;
			3'h3: rd_mux = line_control_q;
			3'h4: rd_mux = div_mode ? 8'h00 : modem_control_q;
			3'h6: rd_mux = (!div_mode && ext_wr_ok) ? flow_threshold_q : 8'h00;
			3'h7: begin
				if (key_mode) begin
					rd_mux = second_pause_char_q;
				end else if (!div_mode && rdy_visible) begin
					rd_mux = fifo_ready_status;
				end else if (!div_mode && ext_wr_ok) begin
					rd_mux = fifo_trigger_level_q;
				end
			end
			default: rd_mux = 8'h00;
		endcase
	end

	// data is presented the cycle after the read strobe and held
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			bus_rdata_q <= 8'h00;
		end else if (bus_rd && !bus_sel_n) begin
			bus_rdata_q <= rd_mux;
		end
	end

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_cts_hold_path: assert property (
		enhanced_feature_ctrl_q[`FEAT_CTS_BIT]
		&& cts_sync_q |=> tx_hold_q)
		else $error("transmitter not held by clear-to-send");
	a_rts_halt_lvl: assert property (
		enhanced_feature_ctrl_q[`FEAT_RTS_BIT] && rts_state_q == uart_flow_pkg::RTS_RESUMED
		&& rx_fill >= halt_lvl |=> ##1 rts_pin_n_q)
		else $error("request-to-send not raised at halt level");
	a_special_flag: assert property (
		rx_char_valid && enhanced_feature_ctrl_q[`FEAT_SPEC_BIT]
		&& rx_char == second_pause_char_q |=> special_char_q)
		else $error("special character match missed");
	a_protect_ien: assert property (
		wr && bus_addr == `ADDR_IEN && !div_mode
		&& !enhanced_feature_ctrl_q[`FEAT_WEN_BIT] |=>
		interrupt_enable_q[7:4] == $past(interrupt_enable_q[7:4]))
		else $error("protected interrupt enable bits changed");
	a_sleep_div_lock: assert property (
		interrupt_enable_q[`IEN_SLEEP_BIT] |=> $stable(divisor_q))
		else $error("divisor changed in sleep mode");
	a_thresh_gate: assert property (
		!ext_wr_ok |=> $stable(flow_threshold_q))
		else $error("threshold written without enable");
	a_trig_gate: assert property (
		!ext_wr_ok |=> $stable(fifo_trigger_level_q))
		else $error("trigger written without enable");
	a_trig_fallback: assert property (
		fifo_trigger_level_q[7:4] == 4'h0 && fifo_control_q[7:6] == 2'd3
		|=> rx_trig_q == `RX_SEL_LVL3)
		else $error("receive trigger fallback wrong");
	a_rdy_read: assert property (
		bus_rd && !bus_sel_n && bus_addr == `ADDR_RDY && !key_mode && !div_mode
		&& rdy_visible |=> bus_rdata_q == $past(fifo_ready_status))
		else $error("ready summary not returned");
	a_reset_clear: assert property (
		$fell(sys_rst) |-> enhanced_feature_ctrl_q == 8'h00
		&& flow_threshold_q == 8'h00)
		else $error("feature registers not cleared by reset");

	c_rts_cycle:    cover property (rts_pin_n_q ##[1:200] !rts_pin_n_q);
	c_special_char: cover property (special_char_q);
	c_rdy_read:     cover property (bus_rd && bus_addr == `ADDR_RDY && rdy_visible);

endmodule : uart_flow_trigger_config

// >>> common/uart_flow_cfg.svh
// constants for the flow, trigger and divisor configuration block
`ifndef UART_FLOW_CFG_SVH
`define UART_FLOW_CFG_SVH

// ----------------------------------------------------------------------------
// register addresses on the 3-bit host bus
// ----------------------------------------------------------------------------
`define ADDR_DIV_LO    3'h0
`define ADDR_DIV_HI    3'h1
`define ADDR_IEN       3'h1
`define ADDR_FEAT      3'h2
`define ADDR_FCTL      3'h2
`define ADDR_LCTL      3'h3
`define ADDR_MCTL      3'h4
`define ADDR_THRESH    3'h6
`define ADDR_TRIG      3'h7
`define ADDR_PAUSE2    3'h7
`define ADDR_RDY       3'h7

// ----------------------------------------------------------------------------
// keys, field positions, masks and reset values
// ----------------------------------------------------------------------------
`define FEAT_KEY       8'hbf
`define LCTL_DIV_BIT   7
`define FEAT_CTS_BIT   7
`define FEAT_RTS_BIT   6
`define FEAT_SPEC_BIT  5
`define FEAT_WEN_BIT   4
`define IEN_SLEEP_BIT  4
`define MCTL_TRIG_BIT  6
`define MCTL_LOOP_BIT  4
`define MCTL_RDY_BIT   2
`define IEN_PROT_MASK  8'hf0
`define FCTL_PROT_MASK 8'h30
`define MCTL_PROT_MASK 8'he0
`define REG_RESET      8'h00

// ----------------------------------------------------------------------------
// fifo geometry and fallback trigger levels picked by fifo_control
// ----------------------------------------------------------------------------
`define FIFO_DEPTH     7'd64
`define RX_SEL_LVL0    6'd8
`define RX_SEL_LVL1    6'd16
`define RX_SEL_LVL2    6'd56
`define RX_SEL_LVL3    6'd60
`define TX_SEL_LVL0    6'd8
`define TX_SEL_LVL1    6'd16
`define TX_SEL_LVL2    6'd32
`define TX_SEL_LVL3    6'd56
`define CHAN_IDX       2

`endif

// >>> common/uart_flow_pkg.sv
// types for the flow, trigger and divisor configuration block
package uart_flow_pkg;

	// receive-side request-to-send hysteresis state
	typedef enum logic {
		RTS_RESUMED,
		RTS_HALTED
	} rts_state_e;

endpackage : uart_flow_pkg

// >>> bench/host_bus_model.sv
// host processor model driving the channel's parallel register bus
`timescale 1ns/10ps
`include "uart_flow_cfg.svh"

module host_bus_model (
	input  wire logic       ref_clk,
	output logic            bus_sel_n,
	output logic      [2:0] bus_addr,
	output logic            bus_wr,
	output logic            bus_rd,
	output logic      [7:0] bus_wdata,
	input  wire logic [7:0] bus_rdata_q
);
	// idle bus from time zero: channel not selected, no strobe
	initial begin
		bus_sel_n = 1'b1;
		bus_addr  = 3'h0;
		bus_wr    = 1'b0;
		bus_rd    = 1'b0;
		bus_wdata = 8'h00;
	end

	// one write, held up to the taking edge; released lines show no stale value
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus_sel_n <= 1'b0;
		bus_addr  <= a;
		bus_wdata <= d;
		bus_wr    <= 1'b1;
		@(posedge ref_clk);
		bus_sel_n <= 1'b1;
		bus_wr    <= 1'b0;
		bus_addr  <= ~a;
		bus_wdata <= ~d;
		#1;
	endtask : wr

	// one read; data is taken once the taking edge has landed
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		bus_sel_n <= 1'b0;
		bus_addr  <= a;
		bus_rd    <= 1'b1;
		@(posedge ref_clk);
		bus_sel_n <= 1'b1;
		bus_rd    <= 1'b0;
		bus_addr  <= ~a;
		#1;
		d = bus_rdata_q;
	endtask : rd

	// feature register is reached only through the line-control key
	task automatic feat(input logic [7:0] d);
		wr(`ADDR_LCTL, `FEAT_KEY);
		wr(`ADDR_FEAT, d);
		wr(`ADDR_LCTL, 8'h00);
	endtask : feat
endmodule : host_bus_model

// >>> bench/testbench.sv
// self-checking bench for the flow, trigger and divisor configuration block
`timescale 1ns/10ps
`include "uart_flow_cfg.svh"

module testbench;
	logic        ref_clk;
	logic        sys_rst;
	logic        bus_sel_n;
	logic [2:0]  bus_addr;
	logic        bus_wr;
	logic        bus_rd;
	logic [7:0]  bus_wdata;
	logic [7:0]  bus_rdata_q;
	logic        cts_pin_n;
	logic        rts_pin_n_q;
	logic        tx_hold_q;
	logic        rx_char_valid;
	logic [7:0]  rx_char;
	logic        special_char_q;
	logic [6:0]  rx_fill;
	logic [6:0]  tx_fill;
	logic        rx_timeout;
	logic [3:0]  peer_rx_ready;
	logic [3:0]  peer_tx_ready;
	logic [15:0] divisor_q;
	logic [3:0]  sw_flow_mode_q;
	logic [5:0]  rx_trig_q;
	logic [5:0]  tx_trig_q;
	logic [7:0]  interrupt_enable_q;
	logic [7:0]  fifo_control_q;
	logic [7:0]  modem_control_q;
	logic [7:0]  line_control_q;
	logic [7:0]  d;
	int          error_cnt;
	int          total_checks;

	// ------------------------------------------------------------------
	// clock, reset and instances
	// ------------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	host_bus_model i_host (.ref_clk(ref_clk), .bus_sel_n(bus_sel_n), .bus_addr(bus_addr),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q));

	uart_flow_trigger_config i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.bus_sel_n(bus_sel_n), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q), .cts_pin_n(cts_pin_n),
		.rts_pin_n_q(rts_pin_n_q), .tx_hold_q(tx_hold_q), .rx_char_valid(rx_char_valid),
		.rx_char(rx_char), .special_char_q(special_char_q), .rx_fill(rx_fill),
		.tx_fill(tx_fill), .rx_timeout(rx_timeout), .peer_rx_ready(peer_rx_ready),
		.peer_tx_ready(peer_tx_ready), .divisor_q(divisor_q), .sw_flow_mode_q(sw_flow_mode_q),
		.rx_trig_q(rx_trig_q), .tx_trig_q(tx_trig_q), .interrupt_enable_q(interrupt_enable_q),
		.fifo_control_q(fifo_control_q), .modem_control_q(modem_control_q),
		.line_control_q(line_control_q));

	// ------------------------------------------------------------------
	// comparison, waiting and closing
	// ------------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// level inputs settle through sync flops, so allow a few edges
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc

	// one received character; match flag expected one edge later
	task automatic rx_one(input logic [7:0] c, input logic exp);
		@(posedge ref_clk);
		rx_char       <= c;
		rx_char_valid <= 1'b1;
		@(posedge ref_clk);
		rx_char_valid <= 1'b0;
		#1;
		chk(special_char_q, exp);
	endtask : rx_one

	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	// watchdog: the sequence needs well under two thousand cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		end_of_test();
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		error_cnt = 0;
		total_checks = 0;
		sys_rst = 1'b1;
		cts_pin_n = 1'b0;
		rx_char_valid = 1'b0;
		rx_char = 8'h00;
		rx_fill = 7'h00;
		tx_fill = 7'h00;
		rx_timeout = 1'b0;
		peer_rx_ready = 4'b1010;
		peer_tx_ready = 4'b1001;
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		cyc(1);
		// reset state and fallback levels
		i_host.wr(`ADDR_LCTL, `FEAT_KEY);
		chk(line_control_q, 16'h00bf);
		i_host.rd(`ADDR_FEAT, d);
		chk(d, 8'h00);
		chk(rx_trig_q, 16'h0008);
		chk(tx_trig_q, 16'h0008);
		// divisor latches while sleep is off
		i_host.wr(`ADDR_LCTL, 8'h80);
		i_host.wr(`ADDR_DIV_LO, 8'h34);
		i_host.wr(`ADDR_DIV_HI, 8'h12);
		chk(divisor_q, 16'h1234);
		i_host.rd(`ADDR_DIV_HI, d);
		chk(d, 8'h12);
		// protected bits with the write enable still clear
		i_host.wr(`ADDR_LCTL, 8'h00);
		i_host.wr(`ADDR_IEN, 8'hff);
		chk(interrupt_enable_q, 8'h0f);
		i_host.wr(`ADDR_FCTL, 8'hff);
		chk(fifo_control_q, 8'hcf);
		i_host.wr(`ADDR_MCTL, 8'hff);
		chk(modem_control_q, 8'h1f);
		cyc(2);
		chk(rx_trig_q, 16'h003c);
		i_host.wr(`ADDR_TRIG, 8'h31);
		cyc(2);
		chk(rx_trig_q, 16'h003c);
		// open the write enable, then sleep blocks the divisor
		i_host.feat(8'h10);
		i_host.wr(`ADDR_IEN, 8'hf0);
		chk(interrupt_enable_q, 8'hf0);
		i_host.wr(`ADDR_LCTL, 8'h80);
		i_host.wr(`ADDR_DIV_LO, 8'hff);
		chk(divisor_q, 16'h1234);
		i_host.wr(`ADDR_LCTL, 8'h00);
		// threshold: blocked without modem bit 6, then halt above resume
		i_host.wr(`ADDR_MCTL, 8'h00);
		i_host.wr(`ADDR_THRESH, 8'h25);
		i_host.wr(`ADDR_MCTL, 8'h40);
		i_host.rd(`ADDR_THRESH, d);
		chk(d, 8'h00);
		i_host.wr(`ADDR_THRESH, 8'h25);
		i_host.rd(`ADDR_THRESH, d);
		chk(d, 8'h25);
		// trigger levels, times four, zero nibble falls back
		i_host.wr(`ADDR_TRIG, 8'h31);
		cyc(2);
		chk(rx_trig_q, 16'h000c);
		chk(tx_trig_q, 16'h0004);
		i_host.wr(`ADDR_TRIG, 8'h30);
		cyc(2);
		chk(tx_trig_q, 16'h0008);
		i_host.wr(`ADDR_FCTL, 8'h30);
		chk(fifo_control_q, 8'h30);
		cyc(2);
		chk(tx_trig_q, 16'h0038);
		// the remaining fallback picks with both nibbles zero
		i_host.wr(`ADDR_TRIG, 8'h00);
		i_host.wr(`ADDR_FCTL, 8'h90);
		cyc(2);
		chk(rx_trig_q, 16'h0038);
		chk(tx_trig_q, 16'h0010);
		i_host.wr(`ADDR_FCTL, 8'h60);
		cyc(2);
		chk(rx_trig_q, 16'h0010);
		chk(tx_trig_q, 16'h0020);
		i_host.wr(`ADDR_TRIG, 8'h31);
		// ready summary at both edges of the fill boundaries
		i_host.wr(`ADDR_MCTL, 8'h44);
		rx_fill <= 7'd13;
		tx_fill <= 7'd60;
		i_host.rd(`ADDR_RDY, d);
		chk(d, 8'hed);
		rx_fill <= 7'd12;
		tx_fill <= 7'd61;
		i_host.rd(`ADDR_RDY, d);
		chk(d, 8'ha9);
		rx_timeout <= 1'b1;
		i_host.rd(`ADDR_RDY, d);
		chk(d, 8'he9);
		rx_timeout <= 1'b0;
		i_host.wr(`ADDR_MCTL, 8'h54);
		i_host.rd(`ADDR_RDY, d);
		chk(d, 8'h31);
		i_host.rd(3'h5, d);
		chk(d, 8'h00);
		// request-to-send hysteresis: halt at 20, resume at 8
		i_host.feat(8'h50);
		rx_fill <= 7'd19;
		cyc(4);
		chk(rts_pin_n_q, 1'b0);
		rx_fill <= 7'd20;
		cyc(4);
		chk(rts_pin_n_q, 1'b1);
		rx_fill <= 7'd9;
		cyc(4);
		chk(rts_pin_n_q, 1'b1);
		rx_fill <= 7'd8;
		cyc(4);
		chk(rts_pin_n_q, 1'b0);
		// clear-to-send gating, disabled then enabled
		cts_pin_n <= 1'b1;
		cyc(4);
		chk(tx_hold_q, 1'b0);
		i_host.feat(8'hd0);
		cyc(4);
		chk(tx_hold_q, 1'b1);
		cts_pin_n <= 1'b0;
		cyc(4);
		chk(tx_hold_q, 1'b0);
		// every software flow combination
		for (int i = 0; i < 16; i++) begin
			i_host.feat({4'h3, i[3:0]});
			chk(sw_flow_mode_q, i[3:0]);
		end
		// special character match and miss, then detection off
		i_host.wr(`ADDR_LCTL, `FEAT_KEY);
		i_host.wr(`ADDR_PAUSE2, 8'h13);
		rx_one(8'h13, 1'b1);
		cyc(1);
		chk(special_char_q, 1'b0);
		rx_one(8'h14, 1'b0);
		i_host.feat(8'h10);
		rx_one(8'h13, 1'b0);
		// second reset mid-run with threshold, trigger and feature loaded
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		cyc(1);
		chk(rx_trig_q, 16'h0008);
		chk(tx_trig_q, 16'h0008);
		i_host.wr(`ADDR_LCTL, `FEAT_KEY);
		i_host.rd(`ADDR_FEAT, d);
		chk(d, 8'h00);
		i_host.wr(`ADDR_FEAT, 8'h10);
		i_host.wr(`ADDR_LCTL, 8'h00);
		i_host.wr(`ADDR_MCTL, 8'h40);
		i_host.rd(`ADDR_THRESH, d);
		chk(d, 8'h00);
		i_host.rd(`ADDR_TRIG, d);
		chk(d, 8'h00);
		end_of_test();
	end
endmodule : testbench
